// >>> hdl/adb_pkg.sv
// Package with build options, formats, register map and timing counts
package adb_pkg;
  // Read path format codes
  localparam logic [1:0] ADB_RD_AES_AES = 2'h0;
  localparam logic [1:0] ADB_RD_AES_PCM = 2'h1;
  localparam logic [1:0] ADB_RD_PCM_PCM = 2'h2;
  localparam logic [1:0] ADB_RD_PCM_AES = 2'h3;
  // Write path format codes
  localparam logic [1:0] ADB_WR_AES_AES = 2'h0;
  localparam logic [1:0] ADB_WR_AES_PCM = 2'h1;
  localparam logic [1:0] ADB_WR_PCM_PCM = 2'h2;
  // Layouts
  localparam logic ADB_LAYOUT_INTERLEAVED = 1'b0;
  localparam logic ADB_LAYOUT_SPLIT = 1'b1;
  // Widths
  localparam int ADB_STREAM_W = 32;
  localparam int ADB_ADDR_MIN = 32;
  localparam int ADB_ADDR_MAX = 64;
  localparam int ADB_CH_W = 3;
  // AES word fields: sample in bits 27:4, side info elsewhere
  localparam int ADB_AES_PCM_LSB = 4;
  localparam int ADB_AES_PCM_W = 24;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADB_REG_CTRL = 8'h00;
  localparam logic [7:0] ADB_REG_FS_MULT = 8'h04;
  localparam logic [7:0] ADB_REG_STATUS = 8'h08;
  localparam logic [7:0] ADB_REG_BUILD = 8'h0c;
  localparam logic [7:0] ADB_REG_RD_COUNT = 8'h10;
  localparam logic [7:0] ADB_REG_WR_COUNT = 8'h14;
  // Control fields
  localparam int ADB_CTRL_RD_RUN = 0;
  localparam int ADB_CTRL_WR_RUN = 1;
  localparam int ADB_CTRL_CH_LSB = 4;
  // Reset values
  localparam logic [31:0] ADB_CTRL_RST = 32'h0000_0020;
  localparam logic [15:0] ADB_FS_MULT_RST = 16'h0100;
  // Buffer depth
  localparam int ADB_BUF_DEPTH = 2;
endpackage

// >>> hdl/adb_sync.sv
// Two-stage level synchroniser, bypassed when clocks are common
`timescale 1ns/1ps
`default_nettype none
module adb_sync
  import adb_pkg::*;
#(
  parameter bit ASYNC = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Level
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  logic hold;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta <= 1'b0;
      hold <= 1'b0;
    end else begin
      meta <= d_i;
      hold <= meta;
    end
  end
  assign q_o = ASYNC ? hold : d_i;
endmodule
`default_nettype wire

// >>> hdl/adb_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adb_skid
  import adb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic [ADB_STREAM_W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [ADB_STREAM_W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [ADB_STREAM_W-1:0] mem [ADB_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
      in_ready_o <= (count + {1'b0, push} - {1'b0, pop}) != 2'h2;
      out_valid_o <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end
  assign out_data_o = mem[rd_ptr];
endmodule
`default_nettype wire

// >>> hdl/adb_top.sv
// Audio DMA build-option layer: format and layout of both paths, pacing of the read path
//
// Behaviour
// R1 - Read path exists only when read_path_present is 1; default present.
// R2 - Write path exists only when write_path_present is 1; default present.
// R3 - Read channel limit is 2, 4, 6 or 8; default 2.
// R4 - Write channel limit is 2, 4, 6 or 8; default 2.
// R5 - Write format: 0 AES kept, 1 AES decoded to PCM, 2 PCM.
// R6 - Read format: 0 AES, 1 AES to PCM, 2 PCM, 3 PCM to AES.
// R7 - AES to PCM read strips side information, outputs sample only.
// R8 - Per-direction layout: 0 interleaved, 1 per-channel storage.
// R9 - Memory address width per direction is 32 to 64 bits.
// R10 - Read async option 1 adds synchronisers; 0 treats clocks common.
// R11 - Write async option 1 adds synchronisers; 0 assumes common clock.
// R12 - Stream data buses are always 32 bits wide.
// R13 - Write PCM source places sample bits at the low end.
// R14 - Read PCM output puts sample bits at the low end.
// R15 - Read samples leave at reference rate over sampling multiplier.
// R16 - Read frame samples leave in ascending channel order.
// R17 - Excluded direction keeps its outputs tied inactive.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module adb_top
  import adb_pkg::*;
#(
  parameter bit read_path_present = 1'b1,
  parameter bit write_path_present = 1'b1,
  parameter int read_channel_limit = 2,
  parameter int write_channel_limit = 2,
  parameter logic [1:0] read_format_select = ADB_RD_PCM_AES,
  parameter logic [1:0] write_format_select = ADB_WR_AES_PCM,
  parameter bit read_layout_select = ADB_LAYOUT_INTERLEAVED,
  parameter bit write_layout_select = ADB_LAYOUT_INTERLEAVED,
  parameter int read_addr_width = 64,
  parameter int write_addr_width = 64,
  parameter bit read_async_option = 1'b1,
  parameter bit write_async_option = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Read path: memory word in, stream out
  input wire logic [ADB_STREAM_W-1:0] rd_mem_data_i,
  input wire logic rd_mem_valid_i,
  output logic rd_mem_ready_o,
  output logic [ADB_STREAM_W-1:0] rd_stream_data_o,
  output logic [ADB_CH_W-1:0] rd_stream_chan_o,
  output logic rd_stream_valid_o,
  input wire logic rd_stream_ready_i,
  output logic [read_addr_width-1:0] rd_mem_addr_o,
  // Write path: stream in, memory word out
  input wire logic [ADB_STREAM_W-1:0] wr_stream_data_i,
  input wire logic wr_stream_valid_i,
  output logic wr_stream_ready_o,
  output logic [ADB_STREAM_W-1:0] wr_mem_data_o,
  output logic wr_mem_valid_o,
  input wire logic wr_mem_ready_i,
  output logic [write_addr_width-1:0] wr_mem_addr_o
);
  // Build checks
  initial begin
    if (!(read_channel_limit inside {2, 4, 6, 8})) begin // R3
      $error("read channel limit must be 2, 4, 6 or 8");
    end
    if (!(write_channel_limit inside {2, 4, 6, 8})) begin // R4
      $error("write channel limit must be 2, 4, 6 or 8");
    end
    if (read_addr_width < ADB_ADDR_MIN || read_addr_width > ADB_ADDR_MAX) begin
      $error("read address width out of range"); // R9
    end
    if (write_addr_width < ADB_ADDR_MIN || write_addr_width > ADB_ADDR_MAX)
    begin
      $error("write address width out of range"); // R9
    end
    if (write_format_select > ADB_WR_PCM_PCM) begin // R5
      $error("write format code must be 0, 1 or 2");
    end
  end

  // Registers
  logic [31:0] ctrl;
  logic [15:0] fs_mult;
  logic [31:0] rd_count;
  logic [31:0] wr_count;

  wire sel_ctrl = reg_addr_i == ADB_REG_CTRL;
  wire sel_fs = reg_addr_i == ADB_REG_FS_MULT;
  wire [2:0] rd_ch_max = 3'(read_channel_limit - 1);
  wire [2:0] wr_ch_max = 3'(write_channel_limit - 1);
  wire [2:0] prog_ch = ctrl[ADB_CTRL_CH_LSB +: 3];
  wire [2:0] rd_last = prog_ch > rd_ch_max ? rd_ch_max : prog_ch;

  // Read-back of block state
  logic rd_run_s;
  logic wr_run_s;
  wire [31:0] status_word = {28'h0, rd_stream_valid_o, wr_mem_valid_o,
                             wr_run_s, rd_run_s};
  wire [31:0] build_word = {8'h00, 7'(read_addr_width), 1'b0,
                            7'(write_addr_width), 1'b0,
                            write_layout_select, read_layout_select,
                            write_format_select, read_format_select,
                            write_path_present, read_path_present};
  wire [31:0] rd_mux =
    reg_addr_i == ADB_REG_CTRL ? ctrl :
    reg_addr_i == ADB_REG_FS_MULT ? {16'h0000, fs_mult} :
    reg_addr_i == ADB_REG_STATUS ? status_word :
    reg_addr_i == ADB_REG_BUILD ? build_word :
    reg_addr_i == ADB_REG_RD_COUNT ? rd_count :
    reg_addr_i == ADB_REG_WR_COUNT ? wr_count : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl <= ADB_CTRL_RST;
      fs_mult <= ADB_FS_MULT_RST;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      if (reg_wr_i && sel_ctrl) begin
        ctrl <= reg_wdata_i;
      end
      if (reg_wr_i && sel_fs) begin
        fs_mult <= reg_wdata_i[15:0];
      end
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // Run bits into each datapath
  adb_sync #(.ASYNC(read_async_option)) u_rd_sync ( // R10
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(ctrl[ADB_CTRL_RD_RUN] & read_path_present),
    .q_o(rd_run_s)
  );
  adb_sync #(.ASYNC(write_async_option)) u_wr_sync ( // R11
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(ctrl[ADB_CTRL_WR_RUN] & write_path_present),
    .q_o(wr_run_s)
  );

  // Read path sample pacing
  logic [15:0] fs_cnt;
  logic fs_tick;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !rd_run_s) begin
      fs_cnt <= 16'h0000;
      fs_tick <= 1'b0;
    end else if (fs_cnt + 16'h0001 >= fs_mult) begin // R15
      fs_cnt <= 16'h0000;
      fs_tick <= 1'b1;
    end else begin
      fs_cnt <= fs_cnt + 16'h0001;
      fs_tick <= 1'b0;
    end
  end

  // Read path format conversion
  logic aes_pre;
  wire [31:0] rd_pcm_part = rd_mem_data_i; // R14
  wire [31:0] rd_aes_strip =
    {8'h00, rd_mem_data_i[ADB_AES_PCM_LSB +: ADB_AES_PCM_W]}; // R7
  wire [31:0] rd_aes_make =
    {4'h0, rd_mem_data_i[ADB_AES_PCM_W-1:0], 3'h0, 1'b0};
  wire [31:0] rd_conv =
    read_format_select == ADB_RD_AES_PCM ? rd_aes_strip :
    read_format_select == ADB_RD_PCM_AES ? rd_aes_make : rd_pcm_part; // R6

  // Read stream output stage, paced by the sample tick
  logic [ADB_STREAM_W-1:0] rd_buf_data;
  logic rd_buf_valid;
  logic rd_buf_ready;
  logic rd_in_ready;
  logic [ADB_CH_W-1:0] rd_chan;
  logic rd_frame_go;
  wire rd_take = read_path_present && rd_mem_valid_i && rd_mem_ready_o;
  wire rd_fire = rd_stream_valid_o && rd_stream_ready_i;
  assign rd_buf_ready = read_path_present && rd_run_s &&
                        (!rd_stream_valid_o || rd_stream_ready_i) &&
                        (rd_frame_go || fs_tick);

  adb_skid u_rd_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_data_i(rd_conv),
    .in_valid_i(rd_take),
    .in_ready_o(rd_in_ready),
    .out_data_o(rd_buf_data),
    .out_valid_o(rd_buf_valid),
    .out_ready_i(rd_buf_ready)
  );

  wire rd_load = rd_buf_valid && rd_buf_ready;
  // Next buffer room, so the registered ready never promises a full slot
  wire next_rd_in_ready = rd_in_ready ?
    !(rd_buf_valid && rd_take && !rd_load) : rd_load;
  // Block start flag rides on the first word that leaves
  wire [31:0] rd_out_word = read_format_select == ADB_RD_PCM_AES ?
    {rd_buf_data[31:1], aes_pre} : rd_buf_data; // R6
  wire [read_addr_width-1:0] rd_step =
    read_layout_select == ADB_LAYOUT_SPLIT ?
      read_addr_width'(4 * read_channel_limit) :
      read_addr_width'(4); // R8
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !read_path_present) begin // R1 R17
      rd_stream_data_o <= 32'h0000_0000;
      rd_stream_valid_o <= 1'b0;
      rd_stream_chan_o <= 3'h0;
      rd_chan <= 3'h0;
      rd_frame_go <= 1'b0;
      rd_mem_ready_o <= 1'b0;
      rd_count <= 32'h0000_0000;
      rd_mem_addr_o <= '0;
      aes_pre <= 1'b1;
    end else begin
      rd_mem_ready_o <= rd_run_s && next_rd_in_ready;
      if (rd_take) begin
        rd_mem_addr_o <= rd_mem_addr_o + rd_step;
      end
      if (rd_load) begin
        rd_stream_data_o <= rd_out_word;
        rd_stream_valid_o <= 1'b1;
        rd_stream_chan_o <= rd_chan;
        rd_count <= rd_count + 32'h0000_0001;
        aes_pre <= 1'b0;
        if (rd_chan >= rd_last) begin // R16
          rd_chan <= 3'h0;
          rd_frame_go <= 1'b0;
        end else begin
          rd_chan <= rd_chan + 3'h1;
          rd_frame_go <= 1'b1;
        end
      end else if (rd_fire) begin
        rd_stream_valid_o <= 1'b0;
      end
    end
  end

  // Write path format conversion
  wire [31:0] wr_conv =
    write_format_select == ADB_WR_AES_PCM ?
      {8'h00, wr_stream_data_i[ADB_AES_PCM_LSB +: ADB_AES_PCM_W]} :
      wr_stream_data_i; // R5 R13
  logic wr_in_ready;
  logic [ADB_STREAM_W-1:0] wr_buf_data;
  logic wr_buf_valid;
  wire wr_take = write_path_present && wr_stream_valid_i &&
                 wr_stream_ready_o;
  wire wr_buf_ready = write_path_present &&
                      (!wr_mem_valid_o || wr_mem_ready_i);
  wire wr_pop = wr_buf_valid && wr_buf_ready;
  // Next buffer room, so the registered ready never promises a full slot
  wire next_wr_in_ready = wr_in_ready ?
    !(wr_buf_valid && wr_take && !wr_pop) : wr_pop;

  adb_skid u_wr_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_data_i(wr_conv),
    .in_valid_i(wr_take),
    .in_ready_o(wr_in_ready),
    .out_data_o(wr_buf_data),
    .out_valid_o(wr_buf_valid),
    .out_ready_i(wr_buf_ready)
  );

  // Interleaved layout steps one word; split layout steps per channel
  logic [ADB_CH_W-1:0] wr_chan;
  wire [write_addr_width-1:0] wr_step =
    write_layout_select == ADB_LAYOUT_SPLIT ?
      write_addr_width'(4 * write_channel_limit) :
      write_addr_width'(4); // R8
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !write_path_present) begin // R2 R17
      wr_mem_data_o <= 32'h0000_0000;
      wr_mem_valid_o <= 1'b0;
      wr_stream_ready_o <= 1'b0;
      wr_mem_addr_o <= '0;
      wr_chan <= 3'h0;
      wr_count <= 32'h0000_0000;
    end else begin
      wr_stream_ready_o <= wr_run_s && next_wr_in_ready;
      if (wr_pop) begin
        wr_mem_data_o <= wr_buf_data; // R12
        wr_mem_valid_o <= 1'b1;
        wr_count <= wr_count + 32'h0000_0001;
        wr_mem_addr_o <= wr_mem_addr_o + wr_step;
        wr_chan <= wr_chan >= wr_ch_max ? 3'h0 : wr_chan + 3'h1;
      end else if (wr_mem_ready_i) begin
        wr_mem_valid_o <= 1'b0;
      end
    end
  end

  // Checks
  rd_order_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
    rd_load && rd_chan < rd_last |=> rd_stream_chan_o == $past(rd_chan))
    else $error("read channel order broken");
  rd_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
    !read_path_present |-> !rd_stream_valid_o && !rd_mem_ready_o)
    else $error("excluded read path active");
  wr_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
    !write_path_present |-> !wr_mem_valid_o && !wr_stream_ready_o)
    else $error("excluded write path active");
  rd_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
    rd_stream_valid_o && !rd_stream_ready_i |=>
    rd_stream_valid_o && $stable(rd_stream_data_o))
    else $error("read stream dropped under stall");
  wr_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
    wr_mem_valid_o && !wr_mem_ready_i |=> $stable(wr_mem_data_o))
    else $error("write word changed under stall");
  rd_strip_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
    read_format_select == ADB_RD_AES_PCM && rd_stream_valid_o |->
    rd_stream_data_o[31:24] == 8'h00)
    else $error("side information left on read stream");
  wr_strip_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
    write_format_select == ADB_WR_AES_PCM && wr_mem_valid_o |->
    wr_mem_data_o[31:24] == 8'h00)
    else $error("side information stored in write path");
  fs_pace_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
    fs_tick && fs_mult > 16'h0001 |=> !fs_tick)
    else $error("sample tick faster than multiplier");
  run_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R10
    !rd_run_s |=> !fs_tick)
    else $error("read pacing while stopped");
  rd_room_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
    rd_take |-> rd_in_ready)
    else $error("read word taken into a full buffer");
  wr_room_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
    wr_take |-> wr_in_ready)
    else $error("write word taken into a full buffer");
  rd_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
    rd_load && rd_chan == 3'h0 |-> fs_tick)
    else $error("read frame started without sample tick");
  aes_first_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
    read_format_select == ADB_RD_PCM_AES && rd_load && !aes_pre |=>
    !rd_stream_data_o[0])
    else $error("block start flag on a later word");
endmodule
`default_nettype wire

// >>> bench/adb_far_model.sv
// Far-side model: read memory source and the sinks of both paths
`timescale 1ns/1ps
`default_nettype none
module adb_far_model
  import adb_pkg::*;
(
  // Clock, reset and stall control
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  // Read path memory and stream sink
  output logic [ADB_STREAM_W-1:0] rd_mem_data_o,
  output logic rd_mem_valid_o,
  input wire logic rd_mem_ready_i,
  output logic rd_stream_ready_o,
  // Write path memory sink
  output logic wr_mem_ready_o
);
  logic [ADB_STREAM_W-1:0] next_word;
  // Both sinks stall together on command
  assign rd_stream_ready_o = !stall_i;
  assign wr_mem_ready_o = !stall_i;
  // Word held until taken, then the next count follows
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      next_word <= 32'h0000_0100;
      rd_mem_valid_o <= 1'b0;
      rd_mem_data_o <= 32'hffff_feff;
    end else if (!rd_mem_valid_o || rd_mem_ready_i) begin
      rd_mem_valid_o <= 1'b1;
      rd_mem_data_o <= next_word;
      next_word <= next_word + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Testbench: registers, read stream pacing and write path buffering
`timescale 1ns/1ps
`default_nettype none
module tb
  import adb_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stall = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic wr_valid = 1'b0;
  logic [31:0] reg_rdata, rd_mem_data, rd_data, wm_data;
  logic [2:0] rd_chan;
  logic [63:0] rd_addr, wm_addr;
  logic rd_mem_valid, rd_mem_ready, rd_valid, rd_ready;
  logic wr_ready, wm_valid, wm_ready, u2_wr_ready, u2_wm_valid;
  int num_errors = 0;
  int samples_checked = 0;
  int rd_k = 0;
  int rd_n = 0;
  int cyc = 0;
  int t0 = 0;
  logic [31:0] exp_q[$];
  logic [31:0] pcm_data = 32'h0000_0001;
  logic [31:0] pcm_exp = 32'h0000_0001;
  logic [31:0] pcm_wm_data;
  logic pcm_ready, pcm_wm_valid;

  always #5 clk_i = ~clk_i;

  adb_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .rd_mem_data_i(rd_mem_data),
    .rd_mem_valid_i(rd_mem_valid), .rd_mem_ready_o(rd_mem_ready),
    .rd_stream_data_o(rd_data), .rd_stream_chan_o(rd_chan),
    .rd_stream_valid_o(rd_valid), .rd_stream_ready_i(rd_ready),
    .rd_mem_addr_o(rd_addr), .wr_stream_data_i(wr_data),
    .wr_stream_valid_i(wr_valid), .wr_stream_ready_o(wr_ready),
    .wr_mem_data_o(wm_data), .wr_mem_valid_o(wm_valid),
    .wr_mem_ready_i(wm_ready), .wr_mem_addr_o(wm_addr));

  adb_top #(.write_path_present(1'b0)) DUT_nowr (.clk_i(clk_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(),
    .rd_mem_data_i(32'h0), .rd_mem_valid_i(1'b0), .rd_mem_ready_o(),
    .rd_stream_data_o(), .rd_stream_chan_o(), .rd_stream_valid_o(),
    .rd_stream_ready_i(1'b1), .rd_mem_addr_o(), .wr_stream_data_i(wr_data),
    .wr_stream_valid_i(wr_valid), .wr_stream_ready_o(u2_wr_ready),
    .wr_mem_data_o(), .wr_mem_valid_o(u2_wm_valid), .wr_mem_ready_i(1'b1),
    .wr_mem_addr_o());

  adb_top #(.read_path_present(1'b0), .write_format_select(ADB_WR_PCM_PCM),
    .write_async_option(1'b0)) DUT_pcm (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(), .rd_mem_data_i(32'h0),
    .rd_mem_valid_i(1'b0), .rd_mem_ready_o(), .rd_stream_data_o(),
    .rd_stream_chan_o(), .rd_stream_valid_o(), .rd_stream_ready_i(1'b1),
    .rd_mem_addr_o(), .wr_stream_data_i(pcm_data), .wr_stream_valid_i(1'b1),
    .wr_stream_ready_o(pcm_ready), .wr_mem_data_o(pcm_wm_data),
    .wr_mem_valid_o(pcm_wm_valid), .wr_mem_ready_i(1'b1), .wr_mem_addr_o());

  adb_far_model far (.clk_i(clk_i), .resetn_i(resetn_i), .stall_i(stall),
    .rd_mem_data_o(rd_mem_data), .rd_mem_valid_o(rd_mem_valid),
    .rd_mem_ready_i(rd_mem_ready), .rd_stream_ready_o(rd_ready),
    .wr_mem_ready_o(wm_ready));

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic results;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    @(posedge clk_i);
    check(reg_rdata, e);
  endtask

  // Offer one AES word; side bits set so decoding must strip them
  task automatic send(input int k, input int lim, output bit took);
    int i;
    wr_data <= {4'hc, 24'h5a0000 + 24'(k), 4'h3};
    wr_valid <= 1'b1;
    took = 1'b0;
    for (i = 0; i < lim && !took; i++) begin
      @(posedge clk_i);
      if (wr_ready === 1'b1) took = 1'b1;
    end
    if (took) exp_q.push_back(32'h005a_0000 + 32'(k));
  endtask

  task automatic bound(input bit ok);
    check({31'h0, ok}, 32'h1);
    if (!ok) results();
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (resetn_i === 1'b1) begin
      check({30'h0, u2_wr_ready, u2_wm_valid}, 32'h0);
      if (rd_mem_valid === 1'b1 && rd_mem_ready === 1'b1) rd_n++;
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        check({29'h0, rd_chan}, 32'(rd_k % 2));
        check(rd_data, {4'h0, 24'h100 + 24'(rd_k), 3'h0, rd_k == 0});
        check({31'h0, rd_data[0]}, {31'h0, rd_k == 0});
        if (rd_chan === 3'h0) begin
          if (rd_k == 2) check(32'(cyc - t0), 32'd16);
          t0 = cyc;
        end
        rd_k++;
      end
      if (wm_valid === 1'b1 && wm_ready === 1'b1) begin
        if (exp_q.size() == 0) check(wm_data, 32'hdead_0000);
        else check(wm_data, exp_q.pop_front());
      end
      if (pcm_ready === 1'b1) pcm_data <= pcm_data + 32'h0000_0001;
      if (pcm_wm_valid === 1'b1) begin
        check(pcm_wm_data, pcm_exp);
        pcm_exp = pcm_exp + 32'h0000_0001;
      end
    end
  end

  initial begin
    int i;
    int n;
    bit took;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(ADB_REG_CTRL, ADB_CTRL_RST);
    rd(ADB_REG_FS_MULT, {16'h0, ADB_FS_MULT_RST});
    rd(ADB_REG_BUILD, 32'h0080_801f);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0);
    wr(ADB_REG_FS_MULT, 32'h10);
    rd(ADB_REG_FS_MULT, 32'h10);
    wr(ADB_REG_CTRL, 32'h13);
    rd(ADB_REG_CTRL, 32'h13);
    for (i = 0; i < 2000 && rd_k < 8; i++) @(posedge clk_i);
    bound(rd_k >= 8);
    // Stall both sinks and fill the write buffer until it refuses
    stall <= 1'b1;
    n = 0;
    took = 1'b1;
    for (i = 0; i < 8 && took; i++) begin
      send(n, 10, took);
      if (took) n++;
    end
    wr_valid <= 1'b0;
    check({31'h0, took}, 32'h0);
    check({31'h0, n >= ADB_BUF_DEPTH}, 32'h1);
    repeat (10) @(posedge clk_i);
    check(rd_addr[31:0], 32'(4 * rd_n));
    check(32'($bits(wm_addr)), 32'd64);
    stall <= 1'b0;
    for (i = 0; i < 6; i++) begin
      send(n, 50, took);
      bound(took);
      n++;
    end
    wr_valid <= 1'b0;
    for (i = 0; i < 2000 && (rd_k < 24 || exp_q.size() != 0); i++)
      @(posedge clk_i);
    bound(rd_k >= 24 && exp_q.size() == 0);
    check(wm_addr[31:0], 32'(4 * n));
    rd(ADB_REG_WR_COUNT, 32'(n));
    results();
  end
endmodule
`default_nettype wire
